// File: common/umh_pkg.sv
// Constants for the serial port modem handshake and pin block
//------------------------------------------------------------------------------
// Notes on behaviour
// - Carrier-detect state readable as modem status bit 7.
// - Carrier-detect pin low-to-high since last status read sets status bit 3.
// - Port interrupt enable bit 3 raises interrupt on any carrier-detect change.
// - Set-ready state readable as modem status bit 5.
// - Set-ready pin low-to-high since last status read sets status bit 1.
// - Port interrupt enable bit 3 raises interrupt on any set-ready change.
// - Request-to-send pin (active low) follows modem control bit 1.
// - Reset returns request-to-send to inactive high.
// - Loopback mode forces request-to-send inactive whatever control holds.
// - Request-to-send pin floats after power-up until software enables it.
// - Request-to-send pin level at reset is caught as base address strap.
// - Clear-to-send shown in status bit 4; its rise sets bit 0.
// - Ring-indicate shown in status bit 6; its rise sets bit 2.
//------------------------------------------------------------------------------
package umh_pkg;

   // Bus shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] OFS_PORT_IE    = 8'h00;
   localparam logic [7:0] OFS_MODEM_CTL  = 8'h04;
   localparam logic [7:0] OFS_MODEM_STAT = 8'h08;
   localparam logic [7:0] OFS_EVT_STAT   = 8'h0C;
   localparam logic [7:0] OFS_EVT_EN     = 8'h10;
   localparam logic [7:0] OFS_EVT_CLR    = 8'h14;
   localparam logic [7:0] OFS_PIN_CFG    = 8'h18;
   localparam logic [7:0] OFS_STRAP      = 8'h1C;

   // Port interrupt enable fields
   localparam int PIE_MODEM_BIT = 3;

   // Modem control fields
   localparam int MC_W        = 5;
   localparam int MC_TERM_BIT = 0;
   localparam int MC_SEND_BIT = 1;
   localparam int MC_AUX1_BIT = 2;
   localparam int MC_AUX2_BIT = 3;
   localparam int MC_LOOP_BIT = 4;

   // Modem status fields
   localparam int MS_CARRIER_BIT   = 7;
   localparam int MS_RING_BIT      = 6;
   localparam int MS_READY_BIT     = 5;
   localparam int MS_CLEAR_BIT     = 4;
   localparam int MS_D_CARRIER_BIT = 3;
   localparam int MS_D_RING_BIT    = 2;
   localparam int MS_D_READY_BIT   = 1;
   localparam int MS_D_CLEAR_BIT   = 0;

   // Synchronised line bundle positions
   localparam int LINE_W     = 6;
   localparam int LN_CLEAR   = 0;
   localparam int LN_READY   = 1;
   localparam int LN_RING    = 2;
   localparam int LN_CARRIER = 3;
   localparam int LN_RX      = 4;
   localparam int LN_SEND    = 5;

   // Block event bits
   localparam int EVT_W         = 2;
   localparam int EVT_MODEM_BIT = 0;
   localparam int EVT_START_BIT = 1;

   // Pin configuration and strap fields
   localparam int PIN_SEND_EN_BIT = 0;
   localparam int STRAP_VAL_BIT   = 0;
   localparam int STRAP_DONE_BIT  = 1;

   // Values after reset
   localparam logic [7:0]       PIE_RST   = 8'h00;
   localparam logic [MC_W-1:0]  MC_RST    = 5'h00;
   localparam logic [EVT_W-1:0] EVT_EN_RST = 2'h3;
   localparam logic [LINE_W-1:0] LINE_RST = 6'h3F;

   // Cycle counts: strap caught once the synchroniser has settled
   localparam int         STRAP_CNT_W  = 2;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage : umh_pkg

// File: common/umh_link_if.sv
// Interface joining the top module with its synchroniser and event block
`timescale 1ns/1ps
interface umh_link_if;
   logic [umh_pkg::LINE_W-1:0] line;
   logic [umh_pkg::EVT_W-1:0]  evt_set;
   logic [umh_pkg::EVT_W-1:0]  evt_clr;
   logic [umh_pkg::EVT_W-1:0]  evt_en;
   logic [umh_pkg::EVT_W-1:0]  evt_stat;
   logic                       irq_line;

   modport sync_src (output line);
   modport evt_side (input evt_set, input evt_clr, input evt_en,
                     output evt_stat, output irq_line);
   modport core (input line, input evt_stat, input irq_line,
                 output evt_set, output evt_clr, output evt_en);
endinterface : umh_link_if

// File: design/umh_sync.sv
// Two-stage synchroniser for the modem and serial input pins
`timescale 1ns/1ps
module umh_sync (
   // Clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       reset,
   // Raw pins
   input  wire logic [umh_pkg::LINE_W-1:0] raw_lines,
   // Synchronised lines
   umh_link_if.sync_src                    lk
);
   import umh_pkg::*;

   logic [LINE_W-1:0] meta;

   // Idle pins sit high, so both stages reset high to avoid a false edge
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         meta    <= LINE_RST;
         lk.line <= LINE_RST;
      end else begin
         meta    <= raw_lines;
         lk.line <= meta;
      end
   end

endmodule : umh_sync

// File: design/umh_evt.sv
// Sticky event status, enable gating and the level interrupt
`timescale 1ns/1ps
module umh_evt (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // Events from the core
   umh_link_if.evt_side lk
);
   import umh_pkg::*;

   logic [EVT_W-1:0] next_stat;

   // A set arriving with its clear wins
   always_comb begin
      next_stat = (lk.evt_stat & ~lk.evt_clr) | lk.evt_set;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         lk.evt_stat <= '0;
         lk.irq_line <= 1'b0;
      end else begin
         lk.evt_stat <= next_stat;
         lk.irq_line <= |(next_stat & lk.evt_en);
      end
   end

   chk_irq_level_follows :
      assert property (@(posedge core_clk) disable iff (reset)
         lk.irq_line == |(lk.evt_stat & $past(lk.evt_en)))
      else $error("interrupt level disagrees with enabled status");

endmodule : umh_evt

// File: design/umh_top.sv
// Modem handshake, pin and register logic of the first serial port
`timescale 1ns/1ps
module umh_top (
   // Clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       reset,
   // APB slave
   input  wire logic [umh_pkg::ADDR_W-1:0] paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [umh_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]                 pstrb,
   output logic      [umh_pkg::DATA_W-1:0] prdata,
   output logic                            pready,
   output logic                            pslverr,
   // Modem handshake pins
   input  wire logic                       carrier_detect_n,
   input  wire logic                       set_ready_n,
   input  wire logic                       clear_send_n,
   input  wire logic                       ring_indicate_n,
   input  wire logic                       request_send_n_in,
   output logic                            request_send_n_out,
   output logic                            request_send_oe_n,
   // Serial data pins
   input  wire logic                       serial_rx_in,
   output logic                            serial_tx_out,
   // Data path side
   input  wire logic                       tx_bit,
   output logic                            rx_bit,
   // Strap and interrupt
   output logic                            base_address_strap,
   output logic                            serial_irq
);
   import umh_pkg::*;

   //---------------------------------------------------------------------------
   // Helpers
   //---------------------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction : hit

   function automatic logic [3:0] rises(input logic [3:0] was,
                                        input logic [3:0] now);
      return ~was & now;
   endfunction : rises

   //---------------------------------------------------------------------------
   // Submodules
   //---------------------------------------------------------------------------
   umh_link_if lk ();

   umh_sync u_sync (
      .core_clk  (core_clk),
      .reset     (reset),
      .raw_lines ({request_send_n_in, serial_rx_in, carrier_detect_n,
                   ring_indicate_n, set_ready_n, clear_send_n}),
      .lk        (lk.sync_src)
   );

   umh_evt u_evt (
      .core_clk (core_clk),
      .reset    (reset),
      .lk       (lk.evt_side)
   );

   //---------------------------------------------------------------------------
   // State
   //---------------------------------------------------------------------------
   logic [7:0]             port_ie;
   logic [MC_W-1:0]        modem_control_reg;
   logic [3:0]             delta;
   logic [3:0]             taken;
   logic [3:0]             prev_n;
   logic                   prev_rx;
   logic [EVT_W-1:0]       evt_en;
   logic                   send_en;
   logic [STRAP_CNT_W-1:0] strap_cnt;
   logic                   strap_done;

   logic                   loop;
   logic [3:0]             eff_n;
   logic [3:0]             rise;
   logic [7:0]             modem_status_reg;
   logic                   line_rx;
   logic                   mapped;
   logic [DATA_W-1:0]      next_rdata;
   logic                   setup;
   logic                   access;
   logic                   wr_en;
   logic                   rd_done;

   //---------------------------------------------------------------------------
   // Line levels
   //---------------------------------------------------------------------------
   assign loop = modem_control_reg[MC_LOOP_BIT];

   // In loopback the status inputs come from the control outputs instead
   always_comb begin
      if (loop) begin
         eff_n = ~{modem_control_reg[MC_AUX2_BIT],
                   modem_control_reg[MC_AUX1_BIT],
                   modem_control_reg[MC_TERM_BIT],
                   modem_control_reg[MC_SEND_BIT]};
         line_rx = tx_bit;
      end else begin
         eff_n   = lk.line[LN_CARRIER:LN_CLEAR];
         line_rx = lk.line[LN_RX];
      end
   end

   assign rise = rises(prev_n, eff_n);
   // Status bits show the asserted state, so they are the pin inverted
   assign modem_status_reg = {~eff_n, delta};

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prev_n  <= LINE_RST[3:0];
         prev_rx <= 1'b1;
      end else begin
         prev_n  <= eff_n;
         prev_rx <= line_rx;
      end
   end

   //---------------------------------------------------------------------------
   // APB slave
   //---------------------------------------------------------------------------
   assign setup   = psel & ~penable;
   assign access  = psel & penable & pready;
   assign wr_en   = access & pwrite & pstrb[0];
   assign rd_done = access & ~pwrite;

   always_comb begin
      mapped     = 1'b1;
      next_rdata = '0;
      case (paddr)
         OFS_PORT_IE:    next_rdata[7:0] = port_ie;
         OFS_MODEM_CTL:  next_rdata[MC_W-1:0] = modem_control_reg;
         OFS_MODEM_STAT: next_rdata[7:0] = modem_status_reg;
         OFS_EVT_STAT:   next_rdata[EVT_W-1:0] = lk.evt_stat;
         OFS_EVT_EN:     next_rdata[EVT_W-1:0] = evt_en;
         OFS_EVT_CLR:    next_rdata = '0;
         OFS_PIN_CFG:    next_rdata[PIN_SEND_EN_BIT] = send_en;
         OFS_STRAP: begin
            next_rdata[STRAP_VAL_BIT]  = base_address_strap;
            next_rdata[STRAP_DONE_BIT] = strap_done;
         end
         default:        mapped = 1'b0;
      endcase
   end

   // No wait state: data is sampled in setup so pready leaves a flop
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
         end
      end
   end

   //---------------------------------------------------------------------------
   // Writable registers
   //---------------------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         port_ie           <= PIE_RST;
         modem_control_reg <= MC_RST;
         evt_en            <= EVT_EN_RST;
         send_en           <= 1'b0;
      end else if (wr_en) begin
         if (hit(paddr, OFS_PORT_IE)) begin
            port_ie <= pwdata[7:0];
         end
         if (hit(paddr, OFS_MODEM_CTL)) begin
            modem_control_reg <= pwdata[MC_W-1:0];
         end
         if (hit(paddr, OFS_EVT_EN)) begin
            evt_en <= pwdata[EVT_W-1:0];
         end
         if (hit(paddr, OFS_PIN_CFG)) begin
            send_en <= pwdata[PIN_SEND_EN_BIT];
         end
      end
   end

   //---------------------------------------------------------------------------
   // Change bits
   //---------------------------------------------------------------------------
   // Only bits that went out in the read data are cleared, so a rise
   // landing between setup and access is kept for the next read
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         taken <= 4'h0;
      end else if (setup & ~pwrite & hit(paddr, OFS_MODEM_STAT)) begin
         taken <= delta;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         delta <= 4'h0;
      end else if (rd_done & hit(paddr, OFS_MODEM_STAT)) begin
         delta <= (delta & ~taken) | rise;
      end else begin
         delta <= delta | rise;
      end
   end

   //---------------------------------------------------------------------------
   // Events and interrupt
   //---------------------------------------------------------------------------
   assign lk.evt_en = evt_en;
   assign lk.evt_clr = (wr_en & hit(paddr, OFS_EVT_CLR)) ?
                       pwdata[EVT_W-1:0] : '0;
   // Any edge of a handshake line counts, not only rises
   // One process drives the whole event word, one driver per signal
   always_comb begin
      lk.evt_set                = '0;
      lk.evt_set[EVT_MODEM_BIT] =
         port_ie[PIE_MODEM_BIT] & |(prev_n ^ eff_n);
      lk.evt_set[EVT_START_BIT] = prev_rx & ~line_rx;
   end
   assign serial_irq = lk.irq_line;

   //---------------------------------------------------------------------------
   // Output pins
   //---------------------------------------------------------------------------
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         request_send_n_out <= 1'b1;
         serial_tx_out      <= 1'b1;
         rx_bit             <= 1'b1;
      end else begin
         request_send_n_out <= loop | ~modem_control_reg[MC_SEND_BIT];
         serial_tx_out      <= loop | tx_bit;
         rx_bit             <= line_rx;
      end
   end

   //---------------------------------------------------------------------------
   // Strap capture and pin release
   //---------------------------------------------------------------------------
   // The pin floats until the strap is caught and software enables it,
   // so the board strap is never fought by our own driver
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         strap_cnt          <= '0;
         strap_done         <= 1'b0;
         base_address_strap <= 1'b0;
      end else if (!strap_done) begin
         strap_cnt <= strap_cnt + 1'b1;
         if (strap_cnt == STRAP_SETTLE) begin
            strap_done         <= 1'b1;
            base_address_strap <= lk.line[LN_SEND];
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         request_send_oe_n <= 1'b1;
      end else begin
         request_send_oe_n <= ~(strap_done & send_en);
      end
   end

   //---------------------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   chk_carrier_state :
      assert property (!loop |-> modem_status_reg[MS_CARRIER_BIT]
                                 == !lk.line[LN_CARRIER])
      else $error("carrier status bit does not follow the pin");

   chk_carrier_delta :
      assert property ($rose(eff_n[3]) |=> delta[MS_D_CARRIER_BIT])
      else $error("carrier rise did not set its change bit");

   chk_carrier_irq :
      assert property ((port_ie[PIE_MODEM_BIT] && evt_en[EVT_MODEM_BIT]
                        && $changed(eff_n[3])) |-> ##[1:2] serial_irq)
      else $error("carrier change raised no interrupt");

   chk_ready_state :
      assert property (!loop |-> modem_status_reg[MS_READY_BIT]
                                 == !lk.line[LN_READY])
      else $error("set-ready status bit does not follow the pin");

   chk_ready_delta :
      assert property ($rose(eff_n[1]) |=> delta[MS_D_READY_BIT])
      else $error("set-ready rise did not set its change bit");

   chk_ready_irq :
      assert property ((port_ie[PIE_MODEM_BIT] && evt_en[EVT_MODEM_BIT]
                        && $changed(eff_n[1])) |-> ##[1:2] serial_irq)
      else $error("set-ready change raised no interrupt");

   chk_send_level :
      assert property (!loop |=> request_send_n_out
                       == !$past(modem_control_reg[MC_SEND_BIT]))
      else $error("send pin does not follow the control bit");

   chk_send_loop :
      assert property (loop |=> request_send_n_out)
      else $error("send pin active in loopback");

   chk_send_float :
      assert property (!strap_done |=> request_send_oe_n)
      else $error("send pin driven before strap capture");

   chk_strap_hold :
      assert property (strap_done |=> strap_done
                       && $stable(base_address_strap))
      else $error("strap value moved after capture");

   chk_clear_delta :
      assert property ($rose(eff_n[0]) |=> delta[MS_D_CLEAR_BIT])
      else $error("clear-to-send rise did not set its change bit");

   chk_ring_delta :
      assert property ($rose(eff_n[2]) |=> delta[MS_D_RING_BIT])
      else $error("ring rise did not set its change bit");

   chk_status_clear :
      assert property ((rd_done && hit(paddr, OFS_MODEM_STAT) && rise == 4'h0)
                       |=> (delta & $past(taken)) == 4'h0)
      else $error("status read left a reported change bit set");

   cov_carrier_read :
      cover property (delta[MS_D_CARRIER_BIT] && rd_done
                      && hit(paddr, OFS_MODEM_STAT));
   cov_irq_raised :
      cover property ($rose(serial_irq));
   cov_loop_mode :
      cover property (loop && $rose(request_send_n_out));
   cov_pin_driven :
      cover property ($fell(request_send_oe_n));

endmodule : umh_top

// File: test/umh_modem_model.sv
// Behavioural modem on the far side of the handshake pins
`timescale 1ns/1ps
module umh_modem_model #(
   parameter logic STRAP_LEVEL = 1'b1
) (
   // Send pin as the block drives it
   input  wire logic request_send_n_out,
   input  wire logic request_send_oe_n,
   // Handshake lines towards the block
   output logic      carrier_detect_n,
   output logic      ring_indicate_n,
   output logic      set_ready_n,
   output logic      clear_send_n,
   // Serial and send pin levels
   output logic      serial_rx_in,
   output logic      request_send_n_in
);
   initial begin
      {carrier_detect_n, ring_indicate_n, set_ready_n, clear_send_n} = 4'hF;
   end

   // No frames are sent, so the receive line idles high
   assign serial_rx_in = 1'b1;

   // Board resistor sets the strap level while the pin floats
   assign request_send_n_in = request_send_oe_n ? STRAP_LEVEL
                                                : request_send_n_out;

   // Called just after a rising edge; pin order carrier, ring, ready, clear
   task automatic set_lines(input logic [3:0] nib);
      {carrier_detect_n, ring_indicate_n, set_ready_n, clear_send_n} <= nib;
   endtask : set_lines
endmodule : umh_modem_model

// File: test/tb_uart_modem_handshake_pins.sv
// Self-checking bench for the modem handshake and pin block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
   miscompares++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_uart_modem_handshake_pins;
   import umh_pkg::*;
   logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic tx_bit = 1, pready, pslverr, rts_out, rts_oe_n, rts_in, irq, tx_out;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, seed = 32'h0000_004F;
   logic cd_n, ri_n, sr_n, cs_n, rx_in, rx_out, strap_out;
   logic [3:0] pstrb = 4'hF;
   logic [32:0] expq[$];
   logic [32:0] exp_v;
   logic [3:0] nib = 4'hF, prev = 4'hF, delta = 4'h0;
   int miscompares = 0, n_tests = 0;

   always #5 core_clk = ~core_clk;

   umh_top u_dut (.core_clk(core_clk), .reset(reset), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .carrier_detect_n(cd_n), .set_ready_n(sr_n), .clear_send_n(cs_n),
      .ring_indicate_n(ri_n), .request_send_n_in(rts_in),
      .request_send_n_out(rts_out), .request_send_oe_n(rts_oe_n),
      .serial_rx_in(rx_in), .serial_tx_out(tx_out), .tx_bit(tx_bit),
      .rx_bit(rx_out), .base_address_strap(strap_out), .serial_irq(irq));

   umh_modem_model u_modem (.request_send_n_out(rts_out),
      .request_send_oe_n(rts_oe_n), .carrier_detect_n(cd_n),
      .ring_indicate_n(ri_n), .set_ready_n(sr_n), .clear_send_n(cs_n),
      .serial_rx_in(rx_in), .request_send_n_in(rts_in));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for pready
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [32:0] ex);
      expq.push_back(ex);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd

   task automatic waitc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : waitc

   // Monitor: each completed read is matched with the oldest note
   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (expq.size() == 0) begin
            `CHK("unexpected read", 33'h0, {pslverr, prdata})
         end else begin
            exp_v = expq.pop_front();
            `CHK("read data", exp_v, {pslverr, prdata})
         end
      end
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   initial begin
      #100us;
      miscompares++;
      give_verdict();
   end

   initial begin
      waitc(3);
      reset <= 1'b0;
      `CHK("send pin", 1'b1, rts_out)
      `CHK("send oe_n", 1'b1, rts_oe_n)
      waitc(6);
      rd(OFS_STRAP, 33'h3);
      `CHK("strap pin", 1'b1, strap_out)
      // A write without its low byte lane must leave the register alone
      pstrb <= 4'h0;
      apb(1'b1, OFS_PORT_IE, 32'h0000_0008);
      pstrb <= 4'hF;
      rd(OFS_PORT_IE, 33'h0);
      $display("Test reset and strap done");
      for (int i = 0; i < 8; i++) begin
         nib = 4'(xs() >> 7);
         u_modem.set_lines(nib);
         tx_bit <= seed[3];
         delta = delta | (nib & ~prev);
         prev = nib;
         waitc(4);
         `CHK("tx pin", tx_bit, tx_out)
         `CHK("rx pin", 1'b1, rx_out)
         rd(OFS_MODEM_STAT, {25'h0, ~nib, delta});
         rd(OFS_MODEM_STAT, {25'h0, ~nib, 4'h0});
         delta = 4'h0;
      end
      rd(OFS_EVT_STAT, 33'h0);
      $display("Test modem status done");
      apb(1'b1, OFS_PORT_IE, 32'h0000_0008);
      rd(OFS_PORT_IE, 33'h8);
      u_modem.set_lines(prev ^ 4'h8);
      waitc(4);
      `CHK("irq carrier", 1'b1, irq)
      rd(OFS_EVT_STAT, 33'h1);
      apb(1'b1, OFS_EVT_EN, 32'h0000_0000);
      waitc(2);
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, OFS_EVT_EN, 32'h0000_0003);
      apb(1'b1, OFS_EVT_CLR, 32'h0000_0001);
      waitc(2);
      `CHK("irq cleared", 1'b0, irq)
      u_modem.set_lines(prev ^ 4'hA);
      waitc(4);
      `CHK("irq ready", 1'b1, irq)
      $display("Test interrupt done");
      apb(1'b1, OFS_MODEM_CTL, 32'h0000_0002);
      waitc(2);
      `CHK("send active", 1'b0, rts_out)
      `CHK("send float", 1'b1, rts_oe_n)
      apb(1'b1, OFS_PIN_CFG, 32'h0000_0001);
      waitc(2);
      `CHK("send driven", 1'b0, rts_oe_n)
      apb(1'b1, OFS_MODEM_CTL, 32'h0000_0012);
      // Loopback turns the receive source over to tx_bit: a start edge
      tx_bit <= 1'b0;
      waitc(2);
      `CHK("send loop", 1'b1, rts_out)
      `CHK("tx loop", 1'b1, tx_out)
      `CHK("rx loop", 1'b0, rx_out)
      rd(OFS_EVT_STAT, 33'h3);
      rd(8'hFC, {1'b1, 32'h0000_0000});
      apb(1'b1, OFS_MODEM_CTL, 32'h0000_0002);
      waitc(2);
      reset <= 1'b1;
      waitc(2);
      `CHK("send after reset", 1'b1, rts_out)
      `CHK("oe after reset", 1'b1, rts_oe_n)
      reset <= 1'b0;
      waitc(2);
      `CHK("send released", 1'b1, rts_out)
      `CHK("oe released", 1'b1, rts_oe_n)
      waitc(4);
      rd(OFS_STRAP, 33'h3);
      $display("Test send pin done");
      waitc(1);
      give_verdict();
   end
endmodule : tb_uart_modem_handshake_pins
